// [hdl/csp_pkg.sv]
package csp_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    // quiet time around a mux change, so no short pulse reaches the core
    localparam int SW_GAP_NS = 300;
    localparam int SW_GAP_CYC = (SW_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IRC_NOMINAL_HZ = 4000000;

    // ------------------------------------------------------------
    // field widths and encodings
    // ------------------------------------------------------------
    localparam int N_W = 8;
    localparam int M_W = 15;
    localparam int CPU_DIV_W = 8;
    localparam int USB_DIV_W = 4;
    localparam int PDIV_CNT_W = 3;

    localparam logic [1:0] SRC_IRC = 2'h0;
    localparam logic [1:0] SRC_MAIN = 2'h1;
    localparam logic [1:0] SRC_RTC = 2'h2;
    localparam logic [1:0] SRC_BAD = 2'h3;

    localparam logic [1:0] WD_IRC = 2'h0;
    localparam logic [1:0] WD_RTC = 2'h1;
    localparam logic [1:0] WD_PCLK = 2'h2;

    localparam logic [1:0] PDIV_4 = 2'h0;
    localparam logic [1:0] PDIV_1 = 2'h1;
    localparam logic [1:0] PDIV_2 = 2'h2;
    localparam logic [1:0] PDIV_8 = 2'h3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [N_W-1:0] RST_N_M1 = 8'h00;
    localparam logic [M_W-1:0] RST_M_M1 = 15'h0000;
    localparam logic [CPU_DIV_W-1:0] RST_CPU_DIV = 8'h00;
    localparam logic [USB_DIV_W-1:0] RST_USB_DIV = 4'h0;

    typedef enum logic [1:0] {
        CSP_RUN = 2'b00,
        CSP_GATE = 2'b01,
        CSP_SWAP = 2'b10,
        CSP_OPEN = 2'b11
    } csp_sw_e;

    typedef struct packed {
        logic [1:0] src_sel;
        logic [N_W-1:0] pre_div_m1;
        logic [M_W-1:0] mult_m1;
        logic pll_enable;
        logic pll_connect;
        logic [CPU_DIV_W-1:0] cpu_div;
        logic [USB_DIV_W-1:0] usb_div;
        logic [1:0] wd_sel;
    } csp_cfg_s;

    typedef struct packed {
        logic [1:0] src;
        logic pll_path;
    } csp_mux_s;

endpackage : csp_pkg

// [hdl/csp_clock_ctrl.sv]
// Behaviour
// - reset selects internal RC oscillator, 4 MHz
// - software picks any of three oscillators
// - pll input pre-divider from 1 to 256
// - feedback divider multiplies from 1 to 32768
// - pll off and bypassed on reset, power-down
// - pll enabled only by software write
// - cpu clock is pll input unless connected
// - each peripheral has its own clock divider
// - main oscillator drives cpu, direct or pll
// - main oscillator is usb pll reference
// - internal RC selectable as watchdog clock
// - rtc oscillator reaches rtc, pll, cpu
// - usb pll off: usb from main pll
// - deep-sleep: pll off, cpu/usb dividers cleared
`timescale 1ns/1ps

module csp_clock_ctrl #(
    parameter int N_PERIPH = 4,
    parameter int SW_GAP = csp_pkg::SW_GAP_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cfg_wr,
    input wire csp_pkg::csp_cfg_s cfg,
    input wire logic [2*N_PERIPH-1:0] periph_div,
    input wire logic power_down,
    input wire logic deep_sleep,
    input wire logic usb_pll_enable,
    input wire logic osc_irc_pin,
    input wire logic osc_main_pin,
    input wire logic osc_rtc_pin,
    input wire logic cco_pin,
    input wire logic pll_lock_pin,
    output logic main_pll_power,
    output logic pll_locked,
    output logic pll_connected,
    output logic [csp_pkg::N_W-1:0] pll_n_value,
    output logic [csp_pkg::M_W-1:0] pll_m_value,
    output logic pll_ref_pulse,
    output logic pll_fb_pulse,
    output csp_pkg::csp_mux_s cpu_mux,
    output logic cpu_clk_gate,
    output logic switch_busy,
    output logic cpu_tick,
    output logic [N_PERIPH-1:0] periph_tick,
    output logic usb_tick,
    output logic usb_clk_from_usb_pll,
    output logic usb_pll_ref_pulse,
    output logic [1:0] watchdog_clock_sel,
    output logic rtc_clk_pulse
);

    initial begin
        if (N_PERIPH < 1 || SW_GAP < 1 || SW_GAP > 255) begin
            $error("csp_clock_ctrl: bad parameter");
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------
    // bit order: 0 irc, 1 main, 2 rtc, 3 cco, 4 lock
    logic [4:0] s1_reg, s2_reg, s3_reg;
    logic [4:0] s1_next, s2_next, s3_next;
    logic [3:0] edge_w;

    always_comb begin
        s1_next = {pll_lock_pin, cco_pin, osc_rtc_pin, osc_main_pin,
                   osc_irc_pin};
        s2_next = s1_reg;
        s3_next = s2_reg;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s1_reg <= 5'h00;
            s2_reg <= 5'h00;
            s3_reg <= 5'h00;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
        end
    end

    assign edge_w = s2_reg[3:0] & ~s3_reg[3:0];

    // ------------------------------------------------------------
    // configuration and pll sequencing
    // ------------------------------------------------------------
    logic [1:0] src_reg, src_next;
    logic [csp_pkg::N_W-1:0] n_reg, n_next;
    logic [csp_pkg::M_W-1:0] m_reg, m_next;
    logic en_reg, en_next;
    logic con_reg, con_next;
    logic [csp_pkg::CPU_DIV_W-1:0] cdiv_reg, cdiv_next;
    logic [csp_pkg::USB_DIV_W-1:0] udiv_reg, udiv_next;
    logic [1:0] wd_reg, wd_next;
    logic locked_w;

    assign locked_w = s2_reg[4];

    always_comb begin
        src_next = src_reg;
        n_next = n_reg;
        m_next = m_reg;
        en_next = en_reg;
        con_next = con_reg;
        cdiv_next = cdiv_reg;
        udiv_next = udiv_reg;
        wd_next = wd_reg;
        if (cfg_wr) begin
            // an unused source code keeps the old choice
            if (cfg.src_sel != csp_pkg::SRC_BAD) begin
                src_next = cfg.src_sel;
            end
            n_next = cfg.pre_div_m1;
            m_next = cfg.mult_m1;
            en_next = cfg.pll_enable;
            con_next = cfg.pll_connect && cfg.pll_enable && en_reg
                       && locked_w;
            cdiv_next = cfg.cpu_div;
            udiv_next = cfg.usb_div;
            if (cfg.wd_sel != csp_pkg::SRC_BAD) begin
                wd_next = cfg.wd_sel;
            end
        end
        // losing lock drops the pll path back to bypass
        if (!locked_w) begin
            con_next = 1'b0;
        end
        if (power_down || deep_sleep) begin
            en_next = 1'b0;
            con_next = 1'b0;
        end
        if (deep_sleep) begin
            cdiv_next = csp_pkg::RST_CPU_DIV;
            udiv_next = csp_pkg::RST_USB_DIV;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            src_reg <= csp_pkg::SRC_IRC;
            n_reg <= csp_pkg::RST_N_M1;
            m_reg <= csp_pkg::RST_M_M1;
            en_reg <= 1'b0;
            con_reg <= 1'b0;
            cdiv_reg <= csp_pkg::RST_CPU_DIV;
            udiv_reg <= csp_pkg::RST_USB_DIV;
            wd_reg <= csp_pkg::WD_IRC;
        end else begin
            src_reg <= src_next;
            n_reg <= n_next;
            m_reg <= m_next;
            en_reg <= en_next;
            con_reg <= con_next;
            cdiv_reg <= cdiv_next;
            udiv_reg <= udiv_next;
            wd_reg <= wd_next;
        end
    end

    // ------------------------------------------------------------
    // glitch-free switch of the cpu clock mux
    // ------------------------------------------------------------
    // the gate closes, the mux moves, the gate reopens; a mux move
    // never happens with the gate open
    csp_pkg::csp_sw_e sw_reg, sw_next;
    csp_pkg::csp_mux_s mux_reg, mux_next;
    logic [7:0] gap_reg, gap_next;
    logic gate_reg, gate_next;
    csp_pkg::csp_mux_s want_w;

    assign want_w = '{src: src_reg, pll_path: con_reg};

    always_comb begin
        sw_next = sw_reg;
        mux_next = mux_reg;
        gap_next = gap_reg;
        gate_next = gate_reg;
        case (sw_reg)
            csp_pkg::CSP_RUN: begin
                if (want_w != mux_reg) begin
                    gate_next = 1'b0;
                    gap_next = 8'(SW_GAP);
                    sw_next = csp_pkg::CSP_GATE;
                end
            end
            csp_pkg::CSP_GATE: begin
                if (gap_reg <= 8'h01) begin
                    mux_next = want_w;
                    gap_next = 8'(SW_GAP);
                    sw_next = csp_pkg::CSP_SWAP;
                end else begin
                    gap_next = gap_reg - 8'h01;
                end
            end
            csp_pkg::CSP_SWAP: begin
                if (gap_reg <= 8'h01) begin
                    gate_next = 1'b1;
                    sw_next = csp_pkg::CSP_OPEN;
                end else begin
                    gap_next = gap_reg - 8'h01;
                end
            end
            default: begin
                sw_next = csp_pkg::CSP_RUN;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sw_reg <= csp_pkg::CSP_RUN;
            mux_reg <= '{src: csp_pkg::SRC_IRC, pll_path: 1'b0};
            gap_reg <= 8'h00;
            gate_reg <= 1'b1;
        end else begin
            sw_reg <= sw_next;
            mux_reg <= mux_next;
            gap_reg <= gap_next;
            gate_reg <= gate_next;
        end
    end

    // ------------------------------------------------------------
    // pre-divider, feedback divider, cpu and usb dividers
    // ------------------------------------------------------------
    logic [csp_pkg::N_W-1:0] ncnt_reg, ncnt_next;
    logic [csp_pkg::M_W-1:0] mcnt_reg, mcnt_next;
    logic [csp_pkg::CPU_DIV_W-1:0] ccnt_reg, ccnt_next;
    logic [csp_pkg::USB_DIV_W-1:0] ucnt_reg, ucnt_next;
    logic ref_reg, ref_next, fb_reg, fb_next;
    logic ctick_reg, ctick_next, utick_reg, utick_next;
    logic src_edge_w, cpu_edge_w;

    // irc, main or rtc edge, whichever feeds the pll input
    assign src_edge_w = (src_reg == csp_pkg::SRC_MAIN) ? edge_w[1] :
                        (src_reg == csp_pkg::SRC_RTC) ? edge_w[2] :
                        edge_w[0];
    assign cpu_edge_w = mux_reg.pll_path ? edge_w[3] :
                        (mux_reg.src == csp_pkg::SRC_MAIN) ? edge_w[1] :
                        (mux_reg.src == csp_pkg::SRC_RTC) ? edge_w[2] :
                        edge_w[0];

    always_comb begin
        ncnt_next = ncnt_reg;
        mcnt_next = mcnt_reg;
        ccnt_next = ccnt_reg;
        ucnt_next = ucnt_reg;
        ref_next = 1'b0;
        fb_next = 1'b0;
        ctick_next = 1'b0;
        utick_next = 1'b0;
        if (!en_reg) begin
            ncnt_next = '0;
            mcnt_next = '0;
        end else begin
            if (src_edge_w) begin
                if (ncnt_reg >= n_reg) begin
                    ncnt_next = '0;
                    ref_next = 1'b1;
                end else begin
                    ncnt_next = ncnt_reg + 1'b1;
                end
            end
            if (edge_w[3]) begin
                if (mcnt_reg >= m_reg) begin
                    mcnt_next = '0;
                    fb_next = 1'b1;
                end else begin
                    mcnt_next = mcnt_reg + 1'b1;
                end
            end
        end
        // a cleared divider stops the clock; the gate also holds it
        if (cpu_edge_w && gate_reg && cdiv_reg != '0) begin
            if (ccnt_reg >= cdiv_reg) begin
                ccnt_next = '0;
                ctick_next = 1'b1;
            end else begin
                ccnt_next = ccnt_reg + 1'b1;
            end
        end
        if (edge_w[3] && en_reg && !usb_pll_enable && udiv_reg != '0) begin
            if (ucnt_reg >= udiv_reg) begin
                ucnt_next = '0;
                utick_next = 1'b1;
            end else begin
                ucnt_next = ucnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ncnt_reg <= '0;
            mcnt_reg <= '0;
            ccnt_reg <= '0;
            ucnt_reg <= '0;
            ref_reg <= 1'b0;
            fb_reg <= 1'b0;
            ctick_reg <= 1'b0;
            utick_reg <= 1'b0;
        end else begin
            ncnt_reg <= ncnt_next;
            mcnt_reg <= mcnt_next;
            ccnt_reg <= ccnt_next;
            ucnt_reg <= ucnt_next;
            ref_reg <= ref_next;
            fb_reg <= fb_next;
            ctick_reg <= ctick_next;
            utick_reg <= utick_next;
        end
    end

    // ------------------------------------------------------------
    // per-peripheral dividers
    // ------------------------------------------------------------
    for (genvar g = 0; g < N_PERIPH; g++) begin : g_periph
        logic [csp_pkg::PDIV_CNT_W-1:0] pc_reg, pc_next, lim_w;
        logic pt_reg, pt_next;
        always_comb begin
            case (periph_div[2*g +: 2])
                csp_pkg::PDIV_1: lim_w = 3'h0;
                csp_pkg::PDIV_2: lim_w = 3'h1;
                csp_pkg::PDIV_8: lim_w = 3'h7;
                default: lim_w = 3'h3;
            endcase
            pc_next = pc_reg;
            pt_next = 1'b0;
            if (ctick_reg) begin
                if (pc_reg >= lim_w) begin
                    pc_next = '0;
                    pt_next = 1'b1;
                end else begin
                    pc_next = pc_reg + 1'b1;
                end
            end
        end
        always_ff @(posedge clock) begin
            if (!rst_n) begin
                pc_reg <= '0;
                pt_reg <= 1'b0;
            end else begin
                pc_reg <= pc_next;
                pt_reg <= pt_next;
            end
        end
        assign periph_tick[g] = pt_reg;
    end

    // ------------------------------------------------------------
    // routing and outputs
    // ------------------------------------------------------------
    logic usbsel_reg, usbref_reg, rtcp_reg;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            usbsel_reg <= 1'b0;
            usbref_reg <= 1'b0;
            rtcp_reg <= 1'b0;
        end else begin
            usbsel_reg <= usb_pll_enable;
            usbref_reg <= edge_w[1];
            rtcp_reg <= edge_w[2];
        end
    end

    assign main_pll_power = en_reg;
    assign pll_locked = locked_w && en_reg;
    assign pll_connected = mux_reg.pll_path;
    assign pll_n_value = n_reg;
    assign pll_m_value = m_reg;
    assign pll_ref_pulse = ref_reg;
    assign pll_fb_pulse = fb_reg;
    assign cpu_mux = mux_reg;
    assign cpu_clk_gate = gate_reg;
    assign switch_busy = (sw_reg != csp_pkg::CSP_RUN);
    assign cpu_tick = ctick_reg;
    assign usb_tick = utick_reg;
    assign usb_clk_from_usb_pll = usbsel_reg;
    assign usb_pll_ref_pulse = usbref_reg;
    assign watchdog_clock_sel = wd_reg;
    assign rtc_clk_pulse = rtcp_reg;

endmodule : csp_clock_ctrl

// [verification/csp_clock_ctrl_props.sv]
`timescale 1ns/1ps

module csp_clock_ctrl_props #(
    parameter int SW_GAP = 3
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cfg_wr,
    input wire csp_pkg::csp_cfg_s cfg,
    input wire logic power_down,
    input wire logic deep_sleep,
    input wire logic usb_pll_enable,
    input wire logic main_pll_power,
    input wire logic pll_locked,
    input wire logic pll_connected,
    input wire logic [csp_pkg::N_W-1:0] pll_n_value,
    input wire logic [csp_pkg::M_W-1:0] pll_m_value,
    input wire csp_pkg::csp_mux_s cpu_mux,
    input wire logic cpu_clk_gate,
    input wire logic cpu_tick,
    input wire logic usb_tick,
    input wire logic [1:0] watchdog_clock_sel
);
    // a switch already under way must finish before the bypass move
    localparam int PD_LAT = 3 * SW_GAP + 4;
    // ----------------------------
    // gate-low cycle counter
    // ----------------------------
    logic [15:0] low_cnt_reg;
    logic [15:0] low_cnt_next;

    always_comb begin
        low_cnt_next = cpu_clk_gate ? 16'h0000 : low_cnt_reg + 16'h0001;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            low_cnt_reg <= 16'h0000;
        end else begin
            low_cnt_reg <= low_cnt_next;
        end
    end

    // ----------------------------
    // properties
    // ----------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_asleep;
        deep_sleep [*2];
    endsequence

    sequence s_usb_own;
        usb_pll_enable [*2];
    endsequence

    chk_reset_irc: assert property (
        $rose(rst_n) |-> cpu_mux == '0 && !main_pll_power && !pll_connected)
        else $error("clock state not at reset values");
    chk_connect_lock: assert property (
        $rose(pll_connected) |-> $past(pll_locked))
        else $error("pll connected while not locked");
    chk_enable_write: assert property (
        $rose(main_pll_power) |-> $past(cfg_wr) && $past(cfg.pll_enable))
        else $error("pll enabled without a software write");
    chk_power_off: assert property (
        power_down |=> !main_pll_power ##[0:PD_LAT] !pll_connected)
        else $error("pll still on in power-down");
    chk_sleep_stop: assert property (
        s_asleep |=> !cpu_tick && !usb_tick && !main_pll_power)
        else $error("clocks still running in deep-sleep");
    chk_usb_route: assert property (
        s_usb_own |=> !usb_tick)
        else $error("usb tick from main pll while usb pll in use");
    chk_wd_select: assert property (
        cfg_wr && cfg.wd_sel != 2'h3 |=>
            watchdog_clock_sel == $past(cfg.wd_sel))
        else $error("watchdog source not taken");
    chk_nm_load: assert property (
        cfg_wr |=> pll_n_value == $past(cfg.pre_div_m1)
            && pll_m_value == $past(cfg.mult_m1))
        else $error("divider or multiplier not loaded");
    chk_mux_quiet: assert property (
        !$stable(cpu_mux) |-> !cpu_clk_gate && low_cnt_reg >= SW_GAP)
        else $error("cpu mux changed without a quiet gap");
    chk_gate_reopen: assert property (
        $rose(cpu_clk_gate) |-> low_cnt_reg >= 2 * SW_GAP)
        else $error("cpu clock gate reopened too early");
endmodule : csp_clock_ctrl_props

bind csp_clock_ctrl csp_clock_ctrl_props #(.SW_GAP(SW_GAP)) props_u (.*);

// [verification/tb_top.sv]
`timescale 1ns/1ps

module tb_top;
    // ----------------------------
    // signals
    // ----------------------------
    localparam int NP = 4;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_wr = 1'b0;
    logic power_down = 1'b0;
    logic deep_sleep = 1'b0;
    logic usb_pll_enable = 1'b0;
    logic pll_lock_pin = 1'b0;
    logic clr = 1'b1;
    logic [2:0] ph = 3'h0;
    // lanes 0..3 divide by 4, 1, 2, 8
    logic [2*NP-1:0] periph_div = 8'hE4;
    csp_pkg::csp_cfg_s cfg = '0;
    csp_pkg::csp_cfg_s c = '0;
    csp_pkg::csp_mux_s cpu_mux;
    logic main_pll_power, pll_locked, pll_connected, cpu_clk_gate;
    logic switch_busy, cpu_tick, usb_tick, usb_clk_from_usb_pll;
    logic usb_pll_ref_pulse, rtc_clk_pulse, pll_ref_pulse, pll_fb_pulse;
    logic [csp_pkg::N_W-1:0] pll_n_value;
    logic [csp_pkg::M_W-1:0] pll_m_value;
    logic [NP-1:0] periph_tick;
    logic [1:0] watchdog_clock_sel;
    int n_errors = 0;
    int n_compared = 0;
    int n_cpu = 0, n_usb = 0, n_ref = 0, n_rtc = 0, n_pref = 0, n_pfb = 0;
    int n_per [NP] = '{default: 0};

    always #50 clock = ~clock;
    // oscillators as square waves, periods of 2, 4 and 8 clocks
    always @(negedge clock) ph <= ph + 3'h1;

    csp_clock_ctrl #(.N_PERIPH(NP), .SW_GAP(3)) dut_u (.*,
        .osc_irc_pin(ph[0]), .osc_main_pin(ph[1]), .osc_rtc_pin(ph[2]),
        .cco_pin(ph[0]));

    always @(posedge clock) begin
        n_cpu <= clr ? 0 : n_cpu + int'(cpu_tick);
        n_usb <= clr ? 0 : n_usb + int'(usb_tick);
        n_ref <= clr ? 0 : n_ref + int'(usb_pll_ref_pulse);
        n_rtc <= clr ? 0 : n_rtc + int'(rtc_clk_pulse);
        n_pref <= clr ? 0 : n_pref + int'(pll_ref_pulse);
        n_pfb <= clr ? 0 : n_pfb + int'(pll_fb_pulse);
        for (int i = 0; i < NP; i++) begin
            n_per[i] <= clr ? 0 : n_per[i] + int'(periph_tick[i]);
        end
    end

    // ----------------------------
    // helpers
    // ----------------------------
    task automatic print_verdict;
        if (n_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic cmp_v(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t: %s got %0h exp %0h", $time, what,
                     got, exp);
        end
    endtask : cmp_v

    // pulse counts: phase of the first pulse allows one either way
    task automatic cmp_n(input int got, input int exp);
        n_compared++;
        if (got < exp - 1 || got > exp + 1) begin
            n_errors++;
            $display("CHECK FAILED %0t: count %0d exp %0d", $time, got, exp);
        end
    endtask : cmp_n

    task automatic wr(input csp_pkg::csp_cfg_s v);
        @(negedge clock);
        cfg = v;
        cfg_wr = 1'b1;
        @(negedge clock);
        cfg_wr = 1'b0;
    endtask : wr

    task automatic count(input int cyc);
        @(negedge clock);
        clr = 1'b1;
        @(negedge clock);
        clr = 1'b0;
        repeat (cyc) @(negedge clock);
    endtask : count

    // busy=1: wait for switch done, busy=0: wait for lock
    task automatic await(input logic busy);
        int k;
        k = 0;
        repeat (2) @(negedge clock);
        while ((busy ? switch_busy !== 1'b0 : pll_locked !== 1'b1)
               && k < 200) begin
            @(negedge clock);
            k++;
        end
        if (k == 200) begin
            n_errors++;
            $display("CHECK FAILED %0t: wait ran out", $time);
            print_verdict();
        end
    endtask : await

    task automatic pll_up;
        c.pll_enable = 1'b1;
        c.pll_connect = 1'b0;
        wr(c);
        pll_lock_pin = 1'b1;
        await(1'b0);
        c.pll_connect = 1'b1;
        wr(c);
        await(1'b1);
    endtask : pll_up

    // ----------------------------
    // scenarios
    // ----------------------------
    task automatic t_reset;
        c = '0;
        cmp_v(cpu_mux, 32'h0, "reset mux");
        cmp_v(cpu_clk_gate, 32'h1, "reset gate");
        cmp_v(main_pll_power, 32'h0, "reset pll");
        cmp_v(pll_connected, 32'h0, "reset connect");
        cmp_v(watchdog_clock_sel, 32'h0, "reset wd");
    endtask : t_reset

    task automatic t_src;
        logic [1:0] sel [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
        logic [1:0] ex [4] = '{2'h1, 2'h2, 2'h2, 2'h0};
        int per [4] = '{8, 16, 16, 4};
        c.cpu_div = 8'h01;
        for (int i = 0; i < 4; i++) begin
            c.src_sel = sel[i];
            wr(c);
            await(1'b1);
            cmp_v(cpu_mux.src, ex[i], "source");
            count(160);
            cmp_n(n_cpu, 160 / per[i]);
        end
    endtask : t_src

    task automatic t_clocks;
        int dv [NP] = '{4, 1, 2, 8};
        count(640);
        for (int i = 0; i < NP; i++) begin
            cmp_n(n_per[i], 160 / dv[i]);
        end
        cmp_n(n_ref, 160);
        cmp_n(n_rtc, 80);
    endtask : t_clocks

    task automatic t_wd;
        logic [1:0] ex [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
        for (int i = 0; i < 4; i++) begin
            c.wd_sel = 2'(i);
            wr(c);
            cmp_v(watchdog_clock_sel, ex[i], "wd source");
        end
    endtask : t_wd

    task automatic t_pll;
        c.pre_div_m1 = 8'hFF;
        c.mult_m1 = 15'h7FFF;
        c.pll_enable = 1'b1;
        c.pll_connect = 1'b1;
        wr(c);
        cmp_v(pll_n_value, 32'hFF, "pre-divider");
        cmp_v(pll_m_value, 32'h7FFF, "multiplier");
        cmp_v(main_pll_power, 32'h1, "enable");
        cmp_v(pll_connected, 32'h0, "early connect");
        wr(c);
        cmp_v(pll_connected, 32'h0, "unlocked connect");
        // small n and m so both divider pulses show within a short count
        c.pre_div_m1 = 8'h03;
        c.mult_m1 = 15'h0001;
        c.pll_connect = 1'b0;
        wr(c);
        count(160);
        cmp_n(n_pref, 20);
        cmp_n(n_pfb, 40);
        pll_up();
        cmp_v(pll_connected, 32'h1, "connect");
        cmp_v(cpu_mux.pll_path, 32'h1, "pll path");
        c.usb_div = 4'h1;
        wr(c);
        count(160);
        cmp_n(n_usb, 40);
        usb_pll_enable = 1'b1;
        count(160);
        cmp_n(n_usb, 0);
        cmp_v(usb_clk_from_usb_pll, 32'h1, "usb pll use");
        usb_pll_enable = 1'b0;
        pll_lock_pin = 1'b0;
        repeat (6) @(negedge clock);
        await(1'b1);
        cmp_v(pll_connected, 32'h0, "lock loss");
        cmp_v(cpu_mux.pll_path, 32'h0, "bypass");
        c.pll_enable = 1'b0;
        c.pll_connect = 1'b0;
        wr(c);
        pll_lock_pin = 1'b1;
        repeat (8) @(negedge clock);
        cmp_v(main_pll_power, 32'h0, "self enable");
    endtask : t_pll

    task automatic t_sleep;
        pll_up();
        deep_sleep = 1'b1;
        count(40);
        cmp_n(n_cpu, 0);
        cmp_v(main_pll_power, 32'h0, "sleep pll");
        cmp_v(pll_connected, 32'h0, "sleep connect");
        deep_sleep = 1'b0;
        await(1'b1);
        count(40);
        cmp_n(n_cpu, 0);
        pll_up();
        power_down = 1'b1;
        wr(c);
        cmp_v(main_pll_power, 32'h0, "down pll");
        await(1'b1);
        cmp_v(pll_connected, 32'h0, "down connect");
        power_down = 1'b0;
    endtask : t_sleep

    initial begin
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        t_reset();
        t_src();
        t_clocks();
        t_wd();
        t_pll();
        t_sleep();
        rst_n = 1'b0;
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        t_reset();
        print_verdict();
    end
endmodule : tb_top
